// ---- rtl/ddr_cap_pkg.sv ----
`default_nettype none
package ddr_cap_pkg;

    localparam int          SET_W       = 6;
    localparam int          CHAIN_ELEMS = 4;
    localparam int          HIST_DEPTH  = 32;
    localparam int          STEP_PS     = 14;
    localparam int          CLK_NS      = 50;

    // register byte offsets
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_OFFSET  = 8'h04;
    localparam logic [7:0]  OFS_SWDELAY = 8'h08;
    localparam logic [7:0]  OFS_STATUS  = 8'h0C;

    // status field positions
    localparam int          STAT_DLL_LSB   = 0;
    localparam int          STAT_FIRST_LSB = 6;
    localparam int          STAT_REST_LSB  = 12;
    localparam int          STAT_PS_LSB    = 18;
    localparam int          PS_W           = 12;

    // phase-comparator counter updates once per eight reference edges
    localparam logic [2:0]  DIV_LAST    = 3'h7;
    localparam logic [2:0]  UPD_PHASE   = 3'h4;

    // sampled pin positions
    localparam int          P_REF  = 0;
    localparam int          P_UPDN = 1;
    localparam int          P_DQS  = 2;
    localparam int          P_DQSN = 3;
    localparam int          P_SYS  = 4;
    localparam int          P_WCLK = 5;
    localparam int          NPIN   = 6;

    localparam int          CTRL_W   = 10;
    localparam logic [9:0]  CTRL_RST = 10'h1B0;
    localparam logic [5:0]  SET_RST  = 6'h00;

    typedef struct packed {
        logic qdr_mode;
        logic oe_delay_sel;
        logic cap_invert;
        logic sel_sw_delay;
        logic upd_gen_en;
        logic latch_en;
        logic zero_shift;
        logic use_offset;
        logic bypass_dll;
        logic offset_add;
    } ctrl_t;

    typedef struct packed {
        logic [SET_W-1:0] first;
        logic [SET_W-1:0] rest;
    } settings_t;

endpackage
`default_nettype wire

// ---- rtl/strobe_delay_chain.sv ----
`timescale 1ns/1ns
`default_nettype none
module strobe_delay_chain #(
    parameter int HIST = ddr_cap_pkg::HIST_DEPTH
) (
    input  wire logic                  clk_in,
    input  wire logic                  rst_b_in,
    input  wire logic                  strobe_in,
    input  wire logic                  zero_shift_in,
    input  wire logic                  gate_en_in,
    input  wire ddr_cap_pkg::settings_t set_in,
    output logic                       shifted_out
);

    typedef struct packed {
        logic [HIST-1:0] hist;
        logic            gate;
        logic            out;
    } chain_t;

    chain_t     st;
    chain_t     nx;
    logic [5:0] dly;
    logic       tap;

    // each element delays by the coarse bits of its setting, in clock samples
    always_comb begin
        nx = st;
        dly = 6'(set_in.first[5:3]) + 6'(6'(ddr_cap_pkg::CHAIN_ELEMS - 1) * 6'(set_in.rest[5:3]));
        if (zero_shift_in || dly == 6'h00) begin
            tap = strobe_in;
        end else begin
            tap = st.hist[5'(dly - 6'h01)];
        end
        nx.hist = {st.hist[HIST-2:0], strobe_in};
        // strobe input register that holds the postamble gate
        nx.gate = gate_en_in;
        nx.out = tap & st.gate;
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign shifted_out = st.out;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    AST_POSTAMBLE_GROUND: assert property (!st.gate |=> !shifted_out)
        else $error("shifted strobe not grounded after postamble");
    AST_ZERO_SHIFT: assert property (zero_shift_in |=> shifted_out == $past(strobe_in & st.gate))
        else $error("zero shift did not bypass the chain");
    COV_GATE_CLOSE: cover property (st.gate ##1 !st.gate ##1 !shifted_out);

endmodule
`default_nettype wire

// ---- rtl/ddr_io_cell.sv ----
`timescale 1ns/1ns
`default_nettype none
module ddr_io_cell #(
    parameter int W = 8
) (
    input  wire logic         clk_in,
    input  wire logic         rst_b_in,
    input  wire logic         cap_rise_in,
    input  wire logic         cap_fall_in,
    input  wire logic         cap_lvl_in,
    input  wire logic         lo_rise_in,
    input  wire logic         qdr_mode_in,
    input  wire logic [W-1:0] data_in,
    input  wire logic         oclk_rise_in,
    input  wire logic         oclk_fall_in,
    input  wire logic         oclk_lvl_in,
    input  wire logic [W-1:0] out_h_in,
    input  wire logic [W-1:0] out_l_in,
    input  wire logic         oe_in,
    input  wire logic         oe_delay_sel_in,
    output logic [W-1:0]      cap_hi_out,
    output logic [W-1:0]      cap_lo_out,
    output logic [W-1:0]      pin_out,
    output logic              pin_oe_out
);

    // six registers and one latch, plus the registered pin drivers
    typedef struct packed {
        logic [W-1:0] a_i;
        logic [W-1:0] b_i;
        logic [W-1:0] c_i;
        logic [W-1:0] a_o;
        logic [W-1:0] b_o;
        logic [W-1:0] pin;
        logic         a_oe_n;
        logic         b_oe_n;
        logic         oe;
    } cell_t;

    cell_t st;
    cell_t nx;
    logic  lo_clk;

    always_comb begin
        nx = st;
        // complementary strobe clocks the low register only in qdr mode
        lo_clk = qdr_mode_in ? lo_rise_in : cap_fall_in;
        if (cap_rise_in) begin
            nx.a_i = data_in;
        end
        if (lo_clk) begin
            nx.b_i = data_in;
        end
        if (cap_lvl_in) begin
            nx.c_i = st.b_i;
        end
        if (oclk_rise_in) begin
            nx.a_o = out_h_in;
            nx.a_oe_n = ~oe_in;
        end
        if (oclk_fall_in) begin
            nx.b_o = out_l_in;
            nx.b_oe_n = st.a_oe_n;
        end
        nx.pin = oclk_lvl_in ? st.a_o : st.b_o;
        // extra half cycle of high impedance gives the write preamble
        nx.oe = oe_delay_sel_in ? ~(st.a_oe_n | st.b_oe_n) : ~st.a_oe_n;
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st <= '{a_oe_n: 1'b1, b_oe_n: 1'b1, default: '0};
        end else begin
            st <= nx;
        end
    end

    // hi/lo swap under an inverted capture clock is left to the consumer
    assign cap_hi_out = st.a_i;
    assign cap_lo_out = st.c_i;
    assign pin_out    = st.pin;
    assign pin_oe_out = st.oe;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    AST_CAP_RISE: assert property (cap_rise_in |=> st.a_i == $past(data_in))
        else $error("rising capture edge did not load high register");
    AST_LATCH_OPEN: assert property (cap_lvl_in |=> st.c_i == $past(st.b_i))
        else $error("input latch not transparent while capture clock high");
    AST_OE_ACTIVE_LOW: assert property (oclk_rise_in |=> st.a_oe_n == !$past(oe_in))
        else $error("first enable register did not take inverted enable");
    AST_OE_EXTEND: assert property (oe_delay_sel_in && st.b_oe_n |=> !pin_oe_out)
        else $error("pin driven during extended preamble");
    COV_PREAMBLE: cover property (oe_delay_sel_in && !st.a_oe_n && st.b_oe_n);

endmodule
`default_nettype wire

// ---- rtl/ddr_strobe_capture_io.sv ----
`timescale 1ns/1ns
`default_nettype none
module ddr_strobe_capture_io #(
    parameter int DQ_W = 8
) (
    input  wire logic            clk_in,
    input  wire logic            rst_b_in,
    input  wire logic [7:0]      addr_in,
    input  wire logic [31:0]     wdata_in,
    input  wire logic            wr_in,
    input  wire logic            rd_in,
    output logic [31:0]          rdata_out,
    input  wire logic            ref_clk_in,
    input  wire logic            updn_in,
    input  wire logic            dqs_in,
    input  wire logic            dqs_n_in,
    input  wire logic            sys_clk_in,
    input  wire logic            wr_clk_in,
    input  wire logic [DQ_W-1:0] dq_in,
    input  wire logic            postamble_en_in,
    input  wire logic [DQ_W-1:0] dq_out_h_in,
    input  wire logic [DQ_W-1:0] dq_out_l_in,
    input  wire logic            dq_oe_in,
    input  wire logic            dqs_out_h_in,
    input  wire logic            dqs_out_l_in,
    input  wire logic            dqs_oe_in,
    output logic                 strobe_bus_out,
    output logic                 strobe_logic_out,
    output logic                 strobe_n_bus_out,
    output logic [DQ_W-1:0]      cap_hi_out,
    output logic [DQ_W-1:0]      cap_lo_out,
    output logic [DQ_W-1:0]      dq_out,
    output logic                 dq_oe_out,
    output logic                 dqs_out,
    output logic                 dqs_oe_out,
    output logic                 update_en_out,
    output logic [5:0]           dll_setting_out
);

    localparam int NPIN = ddr_cap_pkg::NPIN;

    typedef struct packed {
        logic [NPIN-1:0]        s1;
        logic [NPIN-1:0]        s2;
        logic [NPIN-1:0]        prev;
        logic [DQ_W-1:0]        d1;
        logic [DQ_W-1:0]        d2;
        ddr_cap_pkg::ctrl_t     ctrl;
        logic [5:0]             offset;
        logic [5:0]             swdelay;
        logic [5:0]             dll;
        logic [5:0]             lat_delay;
        logic [5:0]             lat_off;
        logic                   lat_add;
        logic [2:0]             div;
        logic                   upd_en;
        logic                   cap_prev;
        logic                   capn_prev;
        logic [31:0]            rdata;
    } state_t;

    state_t                 st;
    state_t                 nx;
    ddr_cap_pkg::settings_t set_c;
    logic [5:0]             src_delay;
    logic                   latch_load;
    logic                   ref_rise;
    logic                   sys_rise;
    logic                   sys_fall;
    logic                   wclk_rise;
    logic                   wclk_fall;
    logic                   strobe_sh;
    logic                   strobe_n_sh;
    logic                   cap_lvl;
    logic                   capn_lvl;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // saturating offset so a large subtraction cannot wrap to a long delay
    function automatic logic [5:0] apply_offset(input logic [5:0] dly, input logic [5:0] off, input logic add);
        logic [6:0] sum;
        sum = add ? ({1'b0, dly} + {1'b0, off}) : ({1'b0, dly} - {1'b0, off});
        if (sum[6]) begin
            return add ? 6'h3F : 6'h00;
        end
        return sum[5:0];
    endfunction

    // total delay of the four elements in steps of roughly 14 ps
    function automatic logic [11:0] delay_ps(input ddr_cap_pkg::settings_t s);
        logic [11:0] steps;
        steps = 12'(s.first) + 12'(12'(ddr_cap_pkg::CHAIN_ELEMS - 1) * 12'(s.rest));
        return 12'(steps * 12'(ddr_cap_pkg::STEP_PS));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // edges of sampled outside clocks

    assign ref_rise  = st.s2[ddr_cap_pkg::P_REF] & ~st.prev[ddr_cap_pkg::P_REF];
    assign sys_rise  = st.s2[ddr_cap_pkg::P_SYS] & ~st.prev[ddr_cap_pkg::P_SYS];
    assign sys_fall  = ~st.s2[ddr_cap_pkg::P_SYS] & st.prev[ddr_cap_pkg::P_SYS];
    assign wclk_rise = st.s2[ddr_cap_pkg::P_WCLK] & ~st.prev[ddr_cap_pkg::P_WCLK];
    assign wclk_fall = ~st.s2[ddr_cap_pkg::P_WCLK] & st.prev[ddr_cap_pkg::P_WCLK];

    // capture clock is the shifted strobe, inverted when cap_invert is set so the last low-half word lands
    assign cap_lvl  = strobe_sh ^ st.ctrl.cap_invert;
    assign capn_lvl = strobe_n_sh ^ st.ctrl.cap_invert;

    ////////////////////////////////////////////////////////////////////////////
    // settings path

    always_comb begin
        src_delay = st.ctrl.sel_sw_delay ? st.swdelay : st.dll;
        // gated by the update pulse; with generator off, any reference edge loads; with latch_en clear, it loads every cycle
        if (!st.ctrl.latch_en) begin
            latch_load = 1'b1;
        end else if (st.ctrl.upd_gen_en) begin
            latch_load = st.upd_en;
        end else begin
            latch_load = ref_rise;
        end
        if (st.ctrl.bypass_dll) begin
            set_c.first = st.lat_off;
            set_c.rest  = 6'h00;
        end else if (st.ctrl.use_offset) begin
            set_c.first = apply_offset(st.lat_delay, st.lat_off, st.lat_add);
            set_c.rest  = st.lat_delay;
        end else begin
            set_c.first = st.lat_delay;
            set_c.rest  = st.lat_delay;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nx = st;
        nx.s1 = {wr_clk_in, sys_clk_in, dqs_n_in, dqs_in, updn_in, ref_clk_in};
        nx.s2 = st.s1;
        nx.prev = st.s2;
        nx.d1 = dq_in;
        nx.d2 = st.d1;
        nx.cap_prev = cap_lvl;
        nx.capn_prev = capn_lvl;

        // phase-comparator counter, one step per eight reference edges
        nx.upd_en = 1'b0;
        if (ref_rise) begin
            nx.div = st.div + 3'h1;
            if (st.div == ddr_cap_pkg::DIV_LAST) begin
                if (st.s2[ddr_cap_pkg::P_UPDN] && st.dll != 6'h3F) begin
                    nx.dll = st.dll + 6'h01;
                end else if (!st.s2[ddr_cap_pkg::P_UPDN] && st.dll != 6'h00) begin
                    nx.dll = st.dll - 6'h01;
                end
            end
            // pulse mid-period so the new count has settled at every block
            nx.upd_en = st.ctrl.upd_gen_en && st.div == ddr_cap_pkg::UPD_PHASE;
        end

        if (latch_load) begin
            nx.lat_delay = src_delay;
            nx.lat_off = st.offset;
            nx.lat_add = st.ctrl.offset_add;
        end

        if (wr_in) begin
            case (addr_in)
                ddr_cap_pkg::OFS_CTRL:    nx.ctrl = ddr_cap_pkg::ctrl_t'(wdata_in[ddr_cap_pkg::CTRL_W-1:0]);
                ddr_cap_pkg::OFS_OFFSET:  nx.offset = wdata_in[5:0];
                ddr_cap_pkg::OFS_SWDELAY: nx.swdelay = wdata_in[5:0];
                default: begin
                end
            endcase
        end

        nx.rdata = 32'h0000_0000;
        if (rd_in) begin
            case (addr_in)
                ddr_cap_pkg::OFS_CTRL:    nx.rdata = 32'(st.ctrl);
                ddr_cap_pkg::OFS_OFFSET:  nx.rdata = 32'(st.offset);
                ddr_cap_pkg::OFS_SWDELAY: nx.rdata = 32'(st.swdelay);
                ddr_cap_pkg::OFS_STATUS: begin
                    nx.rdata[ddr_cap_pkg::STAT_DLL_LSB +: 6] = st.dll;
                    nx.rdata[ddr_cap_pkg::STAT_FIRST_LSB +: 6] = set_c.first;
                    nx.rdata[ddr_cap_pkg::STAT_REST_LSB +: 6] = set_c.rest;
                    nx.rdata[ddr_cap_pkg::STAT_PS_LSB +: ddr_cap_pkg::PS_W] = delay_ps(set_c);
                end
                default: nx.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st <= '{ctrl: ddr_cap_pkg::CTRL_RST, offset: ddr_cap_pkg::SET_RST,
                    swdelay: ddr_cap_pkg::SET_RST, dll: ddr_cap_pkg::SET_RST, default: '0};
        end else begin
            st <= nx;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-pin strobe blocks and i/o cells

    // one block for the true pin and one for the complementary pin
    strobe_delay_chain u_chain_p (
        .clk_in        (clk_in),
        .rst_b_in      (rst_b_in),
        .strobe_in     (st.s2[ddr_cap_pkg::P_DQS]),
        .zero_shift_in (st.ctrl.zero_shift),
        .gate_en_in    (postamble_en_in),
        .set_in        (set_c),
        .shifted_out   (strobe_sh)
    );

    strobe_delay_chain u_chain_n (
        .clk_in        (clk_in),
        .rst_b_in      (rst_b_in),
        .strobe_in     (st.s2[ddr_cap_pkg::P_DQSN]),
        .zero_shift_in (st.ctrl.zero_shift),
        .gate_en_in    (postamble_en_in),
        .set_in        (set_c),
        .shifted_out   (strobe_n_sh)
    );

    // data cell: capture on the shifted strobe, drive on the write clock
    ddr_io_cell #(.W(DQ_W)) u_dq_cell (
        .clk_in          (clk_in),
        .rst_b_in        (rst_b_in),
        .cap_rise_in     (cap_lvl & ~st.cap_prev),
        .cap_fall_in     (~cap_lvl & st.cap_prev),
        .cap_lvl_in      (cap_lvl),
        .lo_rise_in      (capn_lvl & ~st.capn_prev),
        .qdr_mode_in     (st.ctrl.qdr_mode),
        .data_in         (st.d2),
        .oclk_rise_in    (wclk_rise),
        .oclk_fall_in    (wclk_fall),
        .oclk_lvl_in     (st.s2[ddr_cap_pkg::P_WCLK]),
        .out_h_in        (dq_out_h_in),
        .out_l_in        (dq_out_l_in),
        .oe_in           (dq_oe_in),
        .oe_delay_sel_in (1'b0),
        .cap_hi_out      (cap_hi_out),
        .cap_lo_out      (cap_lo_out),
        .pin_out         (dq_out),
        .pin_oe_out      (dq_oe_out)
    );

    // strobe cell runs on the system clock; its capture side is idle
    ddr_io_cell #(.W(1)) u_dqs_cell (
        .clk_in          (clk_in),
        .rst_b_in        (rst_b_in),
        .cap_rise_in     (1'b0),
        .cap_fall_in     (1'b0),
        .cap_lvl_in      (1'b0),
        .lo_rise_in      (1'b0),
        .qdr_mode_in     (1'b0),
        .data_in         (1'b0),
        .oclk_rise_in    (sys_rise),
        .oclk_fall_in    (sys_fall),
        .oclk_lvl_in     (st.s2[ddr_cap_pkg::P_SYS]),
        .out_h_in        (dqs_out_h_in),
        .out_l_in        (dqs_out_l_in),
        .oe_in           (dqs_oe_in),
        .oe_delay_sel_in (st.ctrl.oe_delay_sel),
        .cap_hi_out      (),
        .cap_lo_out      (),
        .pin_out         (dqs_out),
        .pin_oe_out      (dqs_oe_out)
    );

    assign strobe_bus_out   = strobe_sh;
    assign strobe_logic_out = strobe_sh;
    assign strobe_n_bus_out = strobe_n_sh;
    assign rdata_out        = st.rdata;
    assign update_en_out    = st.upd_en;
    assign dll_setting_out  = st.dll;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    AST_DLL_STEP: assert property ($changed(st.dll) |->
        (st.dll == $past(st.dll) + 6'h01) || (st.dll == $past(st.dll) - 6'h01))
        else $error("delay setting moved by more than one step");
    AST_DLL_WHEN: assert property ($changed(st.dll) |-> $past(ref_rise && st.div == 3'h7))
        else $error("delay setting changed off its update edge");
    AST_UPD_GEN: assert property (update_en_out |-> $past(ref_rise && st.div == 3'h4 && st.ctrl.upd_gen_en))
        else $error("update pulse without its reference edge");
    AST_LATCH_HOLD: assert property (st.ctrl.latch_en && st.ctrl.upd_gen_en && !st.upd_en
        |=> $stable(st.lat_delay) && $stable(st.lat_off))
        else $error("latch changed without update pulse");
    AST_LATCH_OPEN: assert property (!st.ctrl.latch_en |=> st.lat_delay == $past(src_delay))
        else $error("disabled latch not transparent");
    AST_BYPASS: assert property (st.ctrl.bypass_dll |-> set_c.first == st.lat_off && set_c.rest == 6'h00)
        else $error("bypass passed more than the offset");
    AST_OFFSET_SUB: assert property (!st.ctrl.bypass_dll && st.ctrl.use_offset && !st.lat_add
        && st.lat_off <= st.lat_delay |-> set_c.first == st.lat_delay - st.lat_off)
        else $error("offset subtraction wrong");
    COV_UPDATE: cover property (update_en_out ##[1:40] $changed(st.lat_delay));
    COV_OFFSET_ADD: cover property (st.ctrl.use_offset && st.lat_add && st.lat_off != 6'h00);

endmodule
`default_nettype wire

// ---- sim/ddr_mem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module ddr_mem_model (
    input  wire logic  go_in,
    output logic       strobe_out,
    output logic       strobe_n_out,
    output logic [7:0] data_out
);
    assign strobe_n_out = ~strobe_out;
    initial begin
        strobe_out = 1'b0;
        data_out = 8'h00;
    end
    // read burst: low preamble, then eight edges with data edge-aligned
    always @(posedge go_in) begin
        #12 strobe_out = 1'b0;
        #200;
        repeat (8) begin
            data_out = data_out + 8'h11;
            strobe_out = ~strobe_out;
            #100;
        end
        // released line has no pull: it later shows the inverse, a glitch the postamble gate must hide
        #1500 {strobe_out, data_out} = ~{strobe_out, data_out};
    end
endmodule
`default_nettype wire

// ---- sim/ddr_strobe_capture_io_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module ddr_strobe_capture_io_bench;
    logic clk_in, rst_b_in, wr_in, rd_in, ref_clk_in, updn_in, dqs_in, dqs_n_in, sys_clk_in, wr_clk_in, go;
    logic postamble_en_in, dq_oe_in, dqs_oe_in, strobe_bus_out, strobe_logic_out, strobe_n_bus_out, watch;
    logic dq_oe_out, dqs_out, dqs_oe_out, update_en_out;
    logic [7:0] addr_in, dq_in, dq_out_h_in, dq_out_l_in, cap_hi_out, cap_lo_out, dq_out;
    logic [31:0] wdata_in, rdata_out, v;
    logic [5:0] dll_setting_out;
    logic [3:0] h;
    logic [1:0] p;
    int n_errors, compares, cyc;
    // ctrl, offset, soft delay, then first element and other elements
    logic [33:0] rows [5] = '{{10'h045, 6'h05, 6'h0A, 6'h0F, 6'h0A}, {10'h044, 6'h0C, 6'h0A, 6'h00, 6'h0A},
        {10'h046, 6'h07, 6'h0A, 6'h07, 6'h00}, {10'h041, 6'h05, 6'h0A, 6'h0A, 6'h0A},
        {10'h045, 6'h3C, 6'h0A, 6'h3F, 6'h0A}};
    ddr_strobe_capture_io u_ddr_strobe_capture_io (.clk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .rdata_out, .ref_clk_in, .updn_in, .dqs_in, .dqs_n_in, .sys_clk_in, .wr_clk_in, .dq_in, .postamble_en_in,
        .dq_out_h_in, .dq_out_l_in, .dq_oe_in, .dqs_out_h_in(1'b1), .dqs_out_l_in(1'b0), .dqs_oe_in,
        .strobe_bus_out, .strobe_logic_out, .strobe_n_bus_out, .cap_hi_out, .cap_lo_out, .dq_out, .dq_oe_out,
        .dqs_out, .dqs_oe_out, .update_en_out, .dll_setting_out);
    ddr_mem_model u_ddr_mem_model (.go_in(go), .strobe_out(dqs_in), .strobe_n_out(dqs_n_in), .data_out(dq_in));
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    initial begin
        {sys_clk_in, wr_clk_in, ref_clk_in} = 3'h0;
        #3;
        fork
            forever #200 sys_clk_in = ~sys_clk_in;
            #100 forever #200 wr_clk_in = ~wr_clk_in;
            #4 forever #200 ref_clk_in = ~ref_clk_in;
        join
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        @(negedge clk_in);
        v = rdata_out;
    endtask
    task automatic give_verdict;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_in) begin
        h <= {h[2:0], dqs_in};
        p <= {p[0], postamble_en_in};
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            give_verdict();
        end
    end
    // two sync stages, then the output register; the gate passes one stage fewer than its pin
    always @(negedge clk_in) if (watch) begin
        chk("strobe_bus", 32'(h[2] & p[1]), 32'(strobe_bus_out));
        chk("strobe_logic", 32'(h[2] & p[1]), 32'(strobe_logic_out));
        chk("strobe_n_bus", 32'(~h[2] & p[1]), 32'(strobe_n_bus_out));
    end
    initial begin
        {rst_b_in, wr_in, rd_in, go, watch, dq_oe_in, dqs_oe_in, addr_in, wdata_in} = 47'h0;
        {updn_in, postamble_en_in, dq_out_h_in, dq_out_l_in} = 18'h3A55A;
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'b1;
        for (int a = 0; a < 5; a++) begin
            rd(8'(a * 4));
            chk("reset_reg", a == 0 ? 32'h000001B0 : 32'h0, v);
        end
        repeat (150) @(posedge clk_in);
        @(negedge clk_in);
        chk("dll_up", 32'h2, 32'(dll_setting_out));
        updn_in <= 1'b0;
        repeat (200) @(posedge clk_in);
        @(negedge clk_in);
        chk("dll_down", 32'h0, 32'(dll_setting_out));
        foreach (rows[i]) begin
            wr(8'h00, 32'(rows[i][33:24]));
            wr(8'h04, 32'(rows[i][23:18]));
            wr(8'h08, 32'(rows[i][17:12]));
            repeat (3) @(posedge clk_in);
            rd(8'h0C);
            chk("first", 32'(rows[i][11:6]), 32'(v[11:6]));
            chk("rest", 32'(rows[i][5:0]), 32'(v[17:12]));
            chk("ps", 32'((rows[i][11:6] + 3 * rows[i][5:0]) * ddr_cap_pkg::STEP_PS), 32'(v[31:18]));
        end
        wr(8'h00, 32'h00000008);
        repeat (4) @(posedge clk_in);
        watch <= 1'b1;
        go <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        repeat (40) @(posedge clk_in);
        postamble_en_in <= 1'b0;
        repeat (20) @(posedge clk_in);
        watch <= 1'b0;
        // strobe not inverted: the last low-half word never reaches the latch
        chk("cap_hi", 32'h77, 32'(cap_hi_out));
        chk("cap_lo", 32'h66, 32'(cap_lo_out));
        wr(8'h00, 32'h00000108);
        {dq_oe_in, dqs_oe_in} <= 2'h3;
        repeat (20) @(posedge clk_in);
        @(posedge wr_clk_in);
        repeat (4) @(negedge clk_in);
        chk("dq_high", 32'hA5, 32'(dq_out));
        chk("dq_oe", 32'h1, 32'(dq_oe_out));
        chk("dqs_oe", 32'h1, 32'(dqs_oe_out));
        chk("dqs_high", 32'h1, 32'(dqs_out));
        @(negedge wr_clk_in);
        repeat (4) @(negedge clk_in);
        chk("dq_low", 32'h5A, 32'(dq_out));
        dq_oe_in <= 1'b0;
        repeat (20) @(posedge clk_in);
        chk("dq_oe_off", 32'h0, 32'(dq_oe_out));
        give_verdict();
    end
endmodule
`default_nettype wire
